// ===== hw/twrb_top.sv
`timescale 1ns/100ps
`include "twrb_defines.svh"

// Function
// - each 16-bit capture or compare word is reached as two byte transfers.
// - every 16-bit timer owns exactly one 8-bit upper-byte holding register.
// - one holding register serves all wide words of a timer; interleaving corrupts.
// - low-byte write to a compare word loads held upper byte and written low byte together.
// - low-byte read captures the word's upper byte into the holding register.
// - covers second timer capture/compare and third timer capture/two compares.
module twrb_top (
  input  wire logic                    mclk_in,
  input  wire logic                    reset_in,
  input  wire twrb_pkg::twrb_cpu_req_t cpu_req_in,
  input  wire twrb_pkg::twrb_capture_t capture_in,
  output logic                   [7:0] cpu_rdata_out,
  output logic                         cpu_rvalid_out,
  output twrb_pkg::twrb_compare_t      compare_out,
  output twrb_pkg::twrb_cmp_load_t     cmp_load_out
);

  // all state of the block apart from the two holding registers
  typedef struct packed {
    twrb_pkg::twrb_compare_t  cmp;
    twrb_pkg::twrb_cmp_load_t cmp_load;
    logic [7:0]               rdata;
    logic                     rvalid;
  } twrb_state_t;

  twrb_state_t st_q;
  twrb_state_t st_d;

  // holding register interface per timer
  logic [7:0] hold2;
  logic [7:0] hold3;
  logic       hold2_load;
  logic       hold3_load;
  logic [7:0] hold2_data;
  logic [7:0] hold3_data;

  // decoded access
  logic       acc_valid;
  logic       acc_wr;
  logic       acc_rd;
  logic       acc_hi;
  logic [7:0] acc_hold;
  logic [15:0] acc_word;
  twrb_pkg::twrb_timer_t acc_tmr;

  // select code in the mapped range
  function automatic logic sel_mapped(input logic [3:0] sel);
    sel_mapped = (sel <= `TWRB_SEL_LAST);
  endfunction : sel_mapped

  // owning timer of a select code
  function automatic twrb_pkg::twrb_timer_t sel_timer(input logic [3:0] sel);
    if (sel < `TWRB_SEL_T3_CAP_LO) begin
      sel_timer = twrb_pkg::TWRB_TMR_SECOND;
    end else begin
      sel_timer = twrb_pkg::TWRB_TMR_THIRD;
    end
  endfunction : sel_timer

  // low byte of a wide word
  function automatic logic [7:0] lo_byte(input logic [15:0] w);
    lo_byte = w[`TWRB_BYTE_LO_MSB:0];
  endfunction : lo_byte

  // high byte of a wide word
  function automatic logic [7:0] hi_byte(input logic [15:0] w);
    hi_byte = w[15:`TWRB_BYTE_HI_LSB];
  endfunction : hi_byte

  // wide word from the held upper byte and a written lower byte
  function automatic logic [15:0] join_word(input logic [7:0] hi, input logic [7:0] lo);
    join_word = {hi, lo};
  endfunction : join_word

  // true when a select code belongs to the second timer's holding register
  function automatic logic owned_by_second(input twrb_pkg::twrb_timer_t t);
    owned_by_second = (t == twrb_pkg::TWRB_TMR_SECOND);
  endfunction : owned_by_second

  // decode of the bus request; a write in the same cycle as a read wins
  // the losing read gets no answer, so no data comes from a cycle that also carried a write
  always_comb begin
    acc_valid = sel_mapped(cpu_req_in.sel);
    acc_wr    = acc_valid & cpu_req_in.wr;
    acc_rd    = acc_valid & cpu_req_in.rd & ~cpu_req_in.wr;
    acc_hi    = cpu_req_in.sel[`TWRB_SEL_HI_BIT];
    acc_tmr   = sel_timer(cpu_req_in.sel);
  end

  // holding register of the addressed timer, shared by all its words
  // every word of a timer lands on this one byte, so an upper-byte write or lower-byte read
  // of another word between the two halves of a pair corrupts that pair
  always_comb begin
    if (owned_by_second(acc_tmr)) begin
      acc_hold = hold2;
    end else begin
      acc_hold = hold3;
    end
  end

  // current 16-bit value of the addressed word
  always_comb begin
    unique case (cpu_req_in.sel[3:1])
      3'h0:    acc_word = capture_in.second_timer_capture_word;
      3'h1:    acc_word = st_q.cmp.second_timer_compare_word;
      3'h2:    acc_word = capture_in.third_timer_capture_word;
      3'h3:    acc_word = st_q.cmp.third_timer_compare_word_a;
      3'h4:    acc_word = st_q.cmp.third_timer_compare_word_b;
      default: acc_word = `TWRB_WORD_RST;  // unmapped codes 0xa..0xf
    endcase
  end

  // holding register loads: upper-byte write or lower-byte read
  always_comb begin
    hold2_load = 1'b0;
    hold3_load = 1'b0;
    hold2_data = cpu_req_in.wdata;
    hold3_data = cpu_req_in.wdata;
    // an upper-byte write to a capture code still loads the byte, so every
    // word of a timer treats the shared byte the same way
    if (acc_wr && acc_hi) begin
      // only the holding register moves; target word untouched
      hold2_load = owned_by_second(acc_tmr);
      hold3_load = !owned_by_second(acc_tmr);
    end else if (acc_rd && !acc_hi) begin
      // snapshot upper byte so a later upper-byte read is coherent, even if
      // the capture word moves between the two reads
      hold2_load = owned_by_second(acc_tmr);
      hold3_load = !owned_by_second(acc_tmr);
      hold2_data = hi_byte(acc_word);
      hold3_data = hi_byte(acc_word);
    end
  end

  // one holding register per timer
  // limitation: nothing here stops an interrupt routine reusing the byte
  // between the two halves of an access; software keeps the pair atomic
  twrb_hold u_hold2 (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .load_in      (hold2_load),
    .load_data_in (hold2_data),
    .hold_out     (hold2)
  );

  twrb_hold u_hold3 (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .load_in      (hold3_load),
    .load_data_in (hold3_data),
    .hold_out     (hold3)
  );

  // next state: compare words, load strobes and read data
  always_comb begin
    st_d          = st_q;
    st_d.cmp_load = '0;
    st_d.rvalid   = 1'b0;
    // low-byte write commits the whole word in one edge; the held byte is
    // not consumed, so several low-byte writes may reuse it
    if (acc_wr && !acc_hi) begin
      unique case (cpu_req_in.sel)
        `TWRB_SEL_T2_CMP_LO: begin
          st_d.cmp.second_timer_compare_word = join_word(acc_hold, cpu_req_in.wdata);
          st_d.cmp_load.second_cmp           = 1'b1;
        end
        `TWRB_SEL_T3_CMPA_LO: begin
          st_d.cmp.third_timer_compare_word_a = join_word(acc_hold, cpu_req_in.wdata);
          st_d.cmp_load.third_cmp_a           = 1'b1;
        end
        `TWRB_SEL_T3_CMPB_LO: begin
          st_d.cmp.third_timer_compare_word_b = join_word(acc_hold, cpu_req_in.wdata);
          st_d.cmp_load.third_cmp_b           = 1'b1;
        end
        // capture words belong to the timer; a write here is dropped
        default: begin
          st_d.cmp = st_q.cmp;
        end
      endcase
    end
    // read answer, registered one cycle after the strobe
    // registering costs a cycle of latency but keeps the data output glitch free
    if (cpu_req_in.rd && !cpu_req_in.wr) begin
      st_d.rvalid = 1'b1;
      if (!acc_valid) begin
        st_d.rdata = `TWRB_RDATA_RST;  // unmapped code reads zero
      end else if (acc_hi) begin
        st_d.rdata = acc_hold;
      end else begin
        st_d.rdata = lo_byte(acc_word);
      end
    end
  end

  // state flops
  // holding registers reset in their own module; the compare words restart from zero
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q.cmp.second_timer_compare_word  <= `TWRB_WORD_RST;
      st_q.cmp.third_timer_compare_word_a <= `TWRB_WORD_RST;
      st_q.cmp.third_timer_compare_word_b <= `TWRB_WORD_RST;
      st_q.cmp_load                       <= '0;
      st_q.rdata                          <= `TWRB_RDATA_RST;
      st_q.rvalid                         <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign cpu_rdata_out  = st_q.rdata;
  assign cpu_rvalid_out = st_q.rvalid;
  assign compare_out    = st_q.cmp;
  assign cmp_load_out   = st_q.cmp_load;

endmodule : twrb_top

// ===== inc/twrb_defines.svh
`ifndef TWRB_DEFINES_SVH
`define TWRB_DEFINES_SVH

// byte select codes seen on the cpu side; bit 0 picks the upper byte
`define TWRB_SEL_T2_CAP_LO   4'h0
`define TWRB_SEL_T2_CAP_HI   4'h1
`define TWRB_SEL_T2_CMP_LO   4'h2
`define TWRB_SEL_T2_CMP_HI   4'h3
`define TWRB_SEL_T3_CAP_LO   4'h4
`define TWRB_SEL_T3_CAP_HI   4'h5
`define TWRB_SEL_T3_CMPA_LO  4'h6
`define TWRB_SEL_T3_CMPA_HI  4'h7
`define TWRB_SEL_T3_CMPB_LO  4'h8
`define TWRB_SEL_T3_CMPB_HI  4'h9
`define TWRB_SEL_LAST        4'h9

// field positions inside a select code and inside a wide word
`define TWRB_SEL_HI_BIT      0
`define TWRB_BYTE_LO_MSB     7
`define TWRB_BYTE_HI_LSB     8

// reset values
`define TWRB_HOLD_RST        8'h00
`define TWRB_WORD_RST        16'h0000
`define TWRB_RDATA_RST       8'h00

`endif

// ===== inc/twrb_pkg.sv
package twrb_pkg;

  // which timer owns a wide register
  typedef enum logic [0:0] {
    TWRB_TMR_SECOND = 1'b0,
    TWRB_TMR_THIRD  = 1'b1
  } twrb_timer_t;

  // one byte access from the cpu data bus
  typedef struct packed {
    logic [3:0] sel;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } twrb_cpu_req_t;

  // live capture words coming from the timers
  typedef struct packed {
    logic [15:0] second_timer_capture_word;
    logic [15:0] third_timer_capture_word;
  } twrb_capture_t;

  // compare words held here and driven to the timers
  typedef struct packed {
    logic [15:0] second_timer_compare_word;
    logic [15:0] third_timer_compare_word_a;
    logic [15:0] third_timer_compare_word_b;
  } twrb_compare_t;

  // one-cycle strobes telling a timer its compare word changed
  typedef struct packed {
    logic second_cmp;
    logic third_cmp_a;
    logic third_cmp_b;
  } twrb_cmp_load_t;

endpackage : twrb_pkg

// ===== hw/twrb_hold.sv
`timescale 1ns/100ps
`include "twrb_defines.svh"

// one upper-byte holding register of a timer
module twrb_hold (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_data_in,
  output logic      [7:0] hold_out
);

  typedef struct packed {
    logic [7:0] hold;
  } twrb_hold_state_t;

  twrb_hold_state_t st_q;
  twrb_hold_state_t st_d;

  // last writer wins; no protection against interleaved accesses
  always_comb begin
    st_d = st_q;
    if (load_in) begin
      st_d.hold = load_data_in;
    end
  end

  // holding register flop
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q.hold <= `TWRB_HOLD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign hold_out = st_q.hold;

endmodule : twrb_hold

// ===== verification/twrb_timer_model.sv
`timescale 1ns/100ps
// far-side timers; a step is a capture event on both
module twrb_timer_model (
  input  wire logic               mclk_in,
  input  wire logic               step_in,
  output twrb_pkg::twrb_capture_t capture_out
);
  // random counts, so a stale byte rarely matches by luck
  initial capture_out = 32'h1a2b_3c4d;
  always @(posedge mclk_in) begin
    if (step_in) begin
      capture_out <= {$urandom};
    end
  end
endmodule : twrb_timer_model

// ===== verification/twrb_top_checker.sv
`timescale 1ns/100ps
// watches the byte path at the top ports only
module twrb_top_checker (
  input wire logic                     mclk_in,
  input wire logic                     reset_in,
  input wire twrb_pkg::twrb_cpu_req_t  cpu_req_in,
  input wire twrb_pkg::twrb_capture_t  capture_in,
  input wire logic               [7:0] cpu_rdata_out,
  input wire logic                     cpu_rvalid_out,
  input wire twrb_pkg::twrb_compare_t  compare_out,
  input wire twrb_pkg::twrb_cmp_load_t cmp_load_out
);
  // short views; a write wins over a read
  wire [3:0]  s = cpu_req_in.sel;
  wire        w = cpu_req_in.wr;
  wire        r = cpu_req_in.rd & ~cpu_req_in.wr;
  wire [7:0]  d = cpu_req_in.wdata;
  wire [15:0] c2 = compare_out.second_timer_compare_word;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  rd_answer_a: assert property (r |=> cpu_rvalid_out) else $error("read lost");
  rvalid_cause_a: assert property (cpu_rvalid_out |-> $past(r)) else $error("stray answer");
  wide_write_a: assert property (w && s == 4'h3 ##1 w && s == 4'h2 |=>
    c2 == {$past(d, 2), $past(d)}) else $error("wide write");
  hi_write_a: assert property (w && s[0] |=> $stable(compare_out) && cmp_load_out == '0)
    else $error("upper write hit word");
  shared_hold_a: assert property (w && s == 4'h3 ##1 w && s == 4'h1 ##1 w && s == 4'h2 |=>
    c2[15:8] == $past(d, 2)) else $error("hold not shared");
  per_timer_a: assert property (w && s == 4'h3 ##1 w && s == 4'h9 ##1 w && s == 4'h2 |=>
    c2[15:8] == $past(d, 3)) else $error("hold crossed timers");
  coherent_rd_a: assert property (r && s == 4'h4 ##1 r && s == 4'h5 |=>
    cpu_rdata_out == $past(capture_in.third_timer_capture_word[15:8], 2)) else $error("torn read");
  cmp_b_load_a: assert property (w && s == 4'h8 |=> cmp_load_out.third_cmp_b &&
    compare_out.third_timer_compare_word_b[7:0] == $past(d)) else $error("word b load");
  cap_lo_a: assert property (r && s == 4'h0 |=>
    cpu_rdata_out == $past(capture_in.second_timer_capture_word[7:0])) else $error("capture low");
  cmp2_load_a: assert property (w && s == 4'h2 |=> cmp_load_out.second_cmp &&
    c2[7:0] == $past(d)) else $error("second compare load");
  cmp_a_load_a: assert property (w && s == 4'h6 |=> cmp_load_out.third_cmp_a &&
    compare_out.third_timer_compare_word_a[7:0] == $past(d)) else $error("word a load");
  dropped_write_a: assert property (w && (s == 4'h0 || s == 4'h4 || s > 4'h9) |=>
    $stable(compare_out) && cmp_load_out == '0) else $error("ignored write took effect");
  cover property (w && s == 4'h3 ##1 w && s == 4'h2);
  cover property (r && s == 4'h4 ##1 r && s == 4'h5);
  cover property (w && s == 4'h7 ##1 w && s == 4'h6 ##1 w && s == 4'h8);
endmodule : twrb_top_checker

bind twrb_top twrb_top_checker u_twrb_top_checker (.mclk_in, .reset_in, .cpu_req_in, .capture_in,
  .cpu_rdata_out, .cpu_rvalid_out, .compare_out, .cmp_load_out);

// ===== verification/twrb_top_tb_top.sv
`timescale 1ns/100ps
// byte accesses in, every read answer checked against a note
module twrb_top_tb_top;
  logic                     mclk_in = 1'b0;
  logic                     reset_in = 1'b1;
  logic                     step = 1'b0;
  twrb_pkg::twrb_cpu_req_t  req = '0;
  twrb_pkg::twrb_capture_t  cap;
  twrb_pkg::twrb_compare_t  cmp;
  twrb_pkg::twrb_cmp_load_t ld;
  logic               [7:0] rdata;
  logic                     rvalid;
  logic               [7:0] notes[$];
  logic              [15:0] v;
  int                       n_fail = 0;
  int                       samples_checked = 0;
  localparam logic    [3:0] LO[3] = '{4'h2, 4'h6, 4'h8};

  twrb_top u_twrb_top (.mclk_in(mclk_in), .reset_in(reset_in), .cpu_req_in(req), .capture_in(cap),
    .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid), .compare_out(cmp), .cmp_load_out(ld));
  twrb_timer_model u_twrb_timer_model (.mclk_in(mclk_in), .step_in(step), .capture_out(cap));

  initial forever #5 mclk_in = ~mclk_in;

  // one access per cycle; a read leaves d as its expected byte
  task automatic acc(input logic [3:0] s, input logic w, input logic [7:0] d);
    @(posedge mclk_in);
    req <= '{s, w, ~w, d};
    if (!w) notes.push_back(d);
  endtask : acc
  task automatic idle(input int n);
    @(posedge mclk_in);
    req <= '0;
    repeat (n) @(posedge mclk_in);
  endtask : idle
  task automatic wr16(input logic [3:0] s, input logic [15:0] x);
    acc(s | 4'h1, 1'b1, x[15:8]);
    acc(s, 1'b1, x[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] s, input logic [15:0] x);
    acc(s, 1'b0, x[7:0]);
    acc(s | 4'h1, 1'b0, x[15:8]);
  endtask : rd16
  // capture moves between the two reads; upper byte must not follow it
  task automatic cap_pair(input logic [3:0] s);
    idle(1);
    v = s[2] ? cap.third_timer_capture_word : cap.second_timer_capture_word;
    acc(s, 1'b0, v[7:0]);
    step <= 1'b1;
    acc(s | 4'h1, 1'b0, v[15:8]);
    step <= 1'b0;
  endtask : cap_pair
  task automatic complete_run;
    if (notes.size() != 0) begin
      n_fail++;
      $display("MISMATCH %0t %0d read answers never came", $time, notes.size());
    end
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // oldest note against each answer
  always @(posedge mclk_in) begin
    if (rvalid === 1'b1) begin
      samples_checked++;
      if (notes.size() == 0 || rdata !== notes[0]) begin
        n_fail++;
        $display("MISMATCH %0t read byte %h", $time, rdata);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end

  // hang guard, far beyond the roughly 110 cycles needed
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h8d8a));
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    acc(4'h3, 1'b0, 8'h00);
    foreach (LO[i]) rd16(LO[i], 16'h0000);
    repeat (3) foreach (LO[i]) begin
      v = 16'($urandom);
      wr16(LO[i], v);
      rd16(LO[i], v);
    end
    acc(4'h3, 1'b1, v[15:8]);
    acc(4'h1, 1'b1, 8'h5a);
    acc(4'h2, 1'b1, v[7:0]);
    rd16(4'h2, {8'h5a, v[7:0]});
    acc(4'h3, 1'b1, 8'h3c);
    acc(4'h9, 1'b1, 8'hc3);
    acc(4'h2, 1'b1, v[7:0]);
    acc(4'h8, 1'b1, v[15:8]);
    rd16(4'h2, {8'h3c, v[7:0]});
    rd16(4'h8, {8'hc3, v[15:8]});
    acc(4'h7, 1'b1, 8'ha5);
    acc(4'h6, 1'b1, 8'h11);
    acc(4'h8, 1'b1, 8'h22);
    rd16(4'h6, 16'ha511);
    rd16(4'h8, 16'ha522);
    acc(4'h7, 1'b1, 8'h99);
    acc(4'h7, 1'b0, 8'h99);
    rd16(4'h6, 16'ha511);
    acc(4'h0, 1'b1, 8'hee);
    acc(4'ha, 1'b1, 8'h77);
    acc(4'ha, 1'b0, 8'h00);
    repeat (3) begin
      cap_pair(4'h0);
      cap_pair(4'h4);
    end
    idle(4);
    complete_run();
  end
endmodule : twrb_top_tb_top
